/* src/pmx_defs.vh */
// constants for the pin mux and reset-state block
`ifndef PMX_DEFS_VH
`define PMX_DEFS_VH
`define PMX_GPIO_W        16
`define PMX_SEL_W         2
`define PMX_SEL_SENS_DEF  2'b00
`define PMX_SEL_GPIO      2'b01
`define PMX_SEL_SENS_ALT  2'b10
`define PMX_EN_RESET      16'h0000
`define PMX_ZERO16        16'h0000
`define PMX_SEL_RESET     2'b00
`define PMX_TRIG_RISE     2'b00
`define PMX_TRIG_FALL     2'b01
`define PMX_TRIG_HIGH     2'b10
`define PMX_TRIG_LOW      2'b11
`define PMX_WAKE_LEVEL    3'h7
`define PMX_OP_WRITE      2'b00
`define PMX_OP_SET        2'b01
`define PMX_OP_CLEAR      2'b10
`define PMX_OP_TOGGLE     2'b11
`define PMX_BIT_SCLK      14
`define PMX_BIT_SDAT      15
`define PMX_BIT_DBG       9
`define PMX_BIT_HSCL      0
`define PMX_BIT_HSDA      1
`define PMX_BIT_IRQO      5
`define PMX_BIT_WAKE      4
`define PMX_BIT_DLYA      5
`define PMX_BIT_DLYB      8
`define PMX_BIT_AN0       6
`define PMX_BIT_AN1       7
`define PMX_BIT_SSPI_LO   2
`define PMX_BIT_SSPI_HI   3
`define PMX_MUX_W         20
`define PMX_MUX_SPI_BOOT  0
`define PMX_MUX_DBG_GPIO  1
`define PMX_MUX_AN        2
`define PMX_MUX_IRQO      3
`define PMX_MUX_DLYA      4
`define PMX_MUX_DLYB      5
`define PMX_MUX_HOST_GPIO 6
`define PMX_MUX_RESET     20'h0_0000
`endif

/* src/pmx_gpio_bit.v */
// one fast gpio bit: data flop with write, set, clear and toggle
`timescale 1ns/10ps
`default_nettype none
`include "pmx_defs.vh"
module pmx_gpio_bit (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       clk_en,
  input  wire       op_valid,
  input  wire [1:0] op_code,
  input  wire       op_mask,
  input  wire       op_data,
  output reg        q_reg
);
  reg q_next;
  always @* begin
    q_next = q_reg;
    if (op_valid && op_mask) begin
      case (op_code)
        `PMX_OP_WRITE:  q_next = op_data;
        `PMX_OP_SET:    q_next = 1'b1;
        `PMX_OP_CLEAR:  q_next = 1'b0;
        `PMX_OP_TOGGLE: q_next = ~q_reg;
        default:        q_next = q_reg;
      endcase
    end
  end
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q_reg <= 1'b0;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end
endmodule
`default_nettype wire

/* src/pmx_pin_mux.v */
// pin mux and reset-state logic of the sensing controller
`timescale 1ns/10ps
`default_nettype none
`include "pmx_defs.vh"
// How it works
// R1 - reset pin input only until enabled
// R2 - drive enabled: pull low on non-por resets
// R3 - host twi pins open-drain inputs, no pullup (code: pullups set per cfg_host_pullup, off at reset)
// R4 - sensor twi on default pins at reset
// R5 - analog pair converted differentially at sample rate
// R6 - analog inputs inactive, gpio 7:6 own
// R7 - sixteen bit port, write/set/clear/toggle ops
// R8 - bits 13:10,8:2 gpio, enable-gated, no pullups
// R9 - bit 9 debug pin, bits 1:0 host
// R10 - bits 15:14 sensor bus when enables 00
// R11 - bits 15:14 gpio when sel 01, enables 11
// R12 - mux register chooses bits 9:0 function
// R13 - wake input programmable edge or level trigger
// R14 - wake presented at priority level seven
// R15 - software raises host interrupt for response
// R16 - response transmit clears host interrupt
// R17 - host interrupt pin defaults to gpio
// R18 - mode pin sampled at power-up exit
// R19 - mode pin becomes single-wire debug link
// R20 - delay outputs routable to pins
// R21 - slave spi pins switch only during boot
// R22 - master spi pins reset as gpio 13:10
// R23 - low strap at startup selects spi slave
// R24 - mux writes take effect next edge
module pmx_pin_mux (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        por_reset,
  input  wire        clk_en,
  // reset control
  input  wire        drive_reset_out,
  input  wire        internal_reset_req,
  input  wire        ext_reset_pin_n_in,
  output wire        ext_reset_pin_n_out,
  output wire        ext_reset_pin_n_oe_n,
  output reg         ext_reset_seen_reg,
  // mux configuration writes
  input  wire        cfg_wr,
  input  wire [15:0] cfg_enable,
  input  wire [1:0]  cfg_clk_sel,
  input  wire [1:0]  cfg_data_sel,
  input  wire [19:0] cfg_mux,
  input  wire [1:0]  cfg_host_pullup,
  input  wire        boot_active,
  // gpio port
  input  wire        gpio_op_valid,
  input  wire [1:0]  gpio_op_code,
  input  wire [15:0] gpio_op_mask,
  input  wire [15:0] gpio_op_data,
  input  wire [15:0] gpio_dir_out,
  output reg  [15:0] gpio_in_reg,
  // internal peripherals
  input  wire        host_twi_clk_out,
  input  wire        host_twi_data_out,
  output reg         host_twi_clk_in_reg,
  output reg         host_twi_data_in_reg,
  input  wire        host_spi_miso_out,
  input  wire        sensor_twi_clk_out,
  input  wire        sensor_twi_data_out,
  output reg         sensor_twi_clk_in_reg,
  output reg         sensor_twi_data_in_reg,
  input  wire        debug_wire_out,
  output reg         debug_wire_in_reg,
  input  wire        delay_out_first,
  input  wire        delay_out_second,
  // host interrupt
  input  wire        host_irq_set,
  input  wire        resp_tx_start,
  output reg         host_irq_reg,
  // wake interrupt
  input  wire [1:0]  wake_trig_mode,
  output reg         wake_req_reg,
  output wire [2:0]  wake_level,
  // analog
  output wire        analog_enable,
  output reg         sample_rate_sync_reg,
  input  wire        sample_rate,
  // straps
  output reg         boot_mode_select_reg,
  output reg         slave_port_strap_reg,
  // pads: in, out, oe_n (low = driving)
  input  wire [15:0] pad_in,
  output reg  [15:0] pad_out_reg,
  output reg  [15:0] pad_oe_n_reg,
  output reg  [15:0] pad_pullup_reg
);
  reg [15:0] enable_reg;
  reg [1:0]  clk_sel_reg;
  reg [1:0]  data_sel_reg;
  reg [19:0] mux_reg;
  reg [1:0]  host_pu_reg;
  reg        drive_en_reg;
  reg        rst_pull_reg;
  reg        rst_pull_d1_reg;
  reg        rst_pull_d2_reg;
  reg [15:0] pad_s1_reg;
  reg [15:0] pad_s2_reg;
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  reg        por_seen_reg;
  reg        wake_prev_reg;
  reg        sdr_s1_reg;
  wire [15:0] gpio_q;
  wire        sens_gpio;
  wire        sens_bus;
  reg  [15:0] out_next;
  reg  [15:0] oe_n_next;
  reg  [15:0] pu_next;
  wire        wake_pin;
  reg         wake_hit;
  integer     k;

  // R7 per-bit port ops
  genvar g;
  generate
    for (g = 0; g < `PMX_GPIO_W; g = g + 1) begin : g_bit
      pmx_gpio_bit u_bit (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .op_valid (gpio_op_valid),
        .op_code  (gpio_op_code),
        .op_mask  (gpio_op_mask[g]),
        .op_data  (gpio_op_data[g]),
        .q_reg    (gpio_q[g])
      );
    end
  endgenerate

  // R24 configuration latch
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enable_reg   <= `PMX_EN_RESET;
      clk_sel_reg  <= `PMX_SEL_RESET;
      data_sel_reg <= `PMX_SEL_RESET;
      mux_reg      <= `PMX_MUX_RESET;
      host_pu_reg  <= 2'b00;
      drive_en_reg <= 1'b0;
    end else if (clk_en) begin
      drive_en_reg <= drive_reset_out;
      if (cfg_wr) begin
        enable_reg   <= cfg_enable;
        clk_sel_reg  <= cfg_clk_sel;
        data_sel_reg <= cfg_data_sel;
        host_pu_reg  <= cfg_host_pullup;
        // R21 slave spi only while booting
        mux_reg[`PMX_MUX_W-1:1] <= cfg_mux[`PMX_MUX_W-1:1];
        if (boot_active) begin
          mux_reg[`PMX_MUX_SPI_BOOT] <= cfg_mux[`PMX_MUX_SPI_BOOT];
        end
      end
    end
  end

  // pad synchronisers carry no reset, so the straps see the pins at release
  always @(posedge core_clk) begin
    if (clk_en) begin
      pad_s1_reg <= pad_in;
      pad_s2_reg <= pad_s1_reg;
    end
  end

  // reset-pin and sample-rate synchronisers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
      sdr_s1_reg <= 1'b0;
      sample_rate_sync_reg <= 1'b0;
    end else if (clk_en) begin
      rst_s1_reg <= ext_reset_pin_n_in;
      rst_s2_reg <= rst_s1_reg;
      sdr_s1_reg <= sample_rate;
      // R5 conversions paced by the sample rate
      sample_rate_sync_reg <= sdr_s1_reg;
    end
  end

  // R1 R2 open-drain reset drive, only after enable, never for por
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rst_pull_reg       <= 1'b0;
      rst_pull_d1_reg    <= 1'b0;
      rst_pull_d2_reg    <= 1'b0;
      ext_reset_seen_reg <= 1'b0;
    end else if (clk_en) begin
      rst_pull_reg       <= drive_en_reg && internal_reset_req && !por_reset;
      rst_pull_d1_reg    <= rst_pull_reg;
      rst_pull_d2_reg    <= rst_pull_d1_reg;
      // own pull stays visible through the pin synchroniser for two edges
      ext_reset_seen_reg <= !rst_s2_reg && !rst_pull_reg &&
                            !rst_pull_d1_reg && !rst_pull_d2_reg;
    end
  end
  assign ext_reset_pin_n_out  = 1'b0;
  assign ext_reset_pin_n_oe_n = !rst_pull_reg;

  // R18 R23 straps caught at the first enabled edge after reset release
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      por_seen_reg         <= 1'b0;
      boot_mode_select_reg <= 1'b1;
      slave_port_strap_reg <= 1'b1;
    end else if (clk_en && !por_seen_reg) begin
      por_seen_reg         <= 1'b1;
      boot_mode_select_reg <= pad_s2_reg[`PMX_BIT_DBG];
      slave_port_strap_reg <= pad_s2_reg[`PMX_BIT_DLYB];
    end
  end

  // R10 R11 sensor pair ownership
  assign sens_gpio = (clk_sel_reg == `PMX_SEL_GPIO) && (data_sel_reg == `PMX_SEL_GPIO) &&
                     enable_reg[`PMX_BIT_SCLK] && enable_reg[`PMX_BIT_SDAT];
  assign sens_bus  = !sens_gpio;

  // R6 analog inactive until muxed in
  assign analog_enable = mux_reg[`PMX_MUX_AN];

  always @* begin
    out_next  = `PMX_ZERO16;
    oe_n_next = {`PMX_GPIO_W{1'b1}};
    pu_next   = `PMX_ZERO16;
    // R8 R22 enable-gated gpio, pullups off
    for (k = 0; k < `PMX_GPIO_W; k = k + 1) begin
      if (enable_reg[k] && gpio_dir_out[k]) begin
        out_next[k]  = gpio_q[k];
        oe_n_next[k] = 1'b0;
      end
    end
    // R4 sensor twi open-drain on its default pins
    if (sens_bus) begin
      oe_n_next[`PMX_BIT_SCLK] = sensor_twi_clk_out;
      oe_n_next[`PMX_BIT_SDAT] = sensor_twi_data_out;
      out_next[`PMX_BIT_SCLK]  = 1'b0;
      out_next[`PMX_BIT_SDAT]  = 1'b0;
    end
    // R9 R19 R12 debug wire owns bit 9 unless muxed to gpio
    if (!mux_reg[`PMX_MUX_DBG_GPIO]) begin
      out_next[`PMX_BIT_DBG]  = 1'b0;
      oe_n_next[`PMX_BIT_DBG] = !por_seen_reg || debug_wire_out;
    end
    // R3 R9 host twi open-drain inputs, pullups per config
    if (!mux_reg[`PMX_MUX_HOST_GPIO]) begin
      out_next[`PMX_BIT_HSCL]  = 1'b0;
      out_next[`PMX_BIT_HSDA]  = 1'b0;
      oe_n_next[`PMX_BIT_HSCL] = host_twi_clk_out;
      oe_n_next[`PMX_BIT_HSDA] = host_twi_data_out;
      pu_next[`PMX_BIT_HSCL]   = host_pu_reg[0];
      pu_next[`PMX_BIT_HSDA]   = host_pu_reg[1];
    end
    // R21 slave spi output on bit 2
    if (mux_reg[`PMX_MUX_SPI_BOOT]) begin
      out_next[`PMX_BIT_SSPI_LO]  = host_spi_miso_out;
      oe_n_next[`PMX_BIT_SSPI_LO] = 1'b0;
      oe_n_next[`PMX_BIT_SSPI_HI] = 1'b1;
    end
    // R20 delay outputs to pins
    if (mux_reg[`PMX_MUX_DLYA]) begin
      out_next[`PMX_BIT_DLYA]  = delay_out_first;
      oe_n_next[`PMX_BIT_DLYA] = 1'b0;
    end
    if (mux_reg[`PMX_MUX_DLYB]) begin
      out_next[`PMX_BIT_DLYB]  = delay_out_second;
      oe_n_next[`PMX_BIT_DLYB] = 1'b0;
    end
    // R15 R17 host interrupt on bit 5 only when muxed
    if (mux_reg[`PMX_MUX_IRQO]) begin
      out_next[`PMX_BIT_IRQO]  = host_irq_reg;
      oe_n_next[`PMX_BIT_IRQO] = 1'b0;
    end
    if (analog_enable) begin
      oe_n_next[`PMX_BIT_AN0] = 1'b1;
      oe_n_next[`PMX_BIT_AN1] = 1'b1;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pad_out_reg    <= `PMX_ZERO16;
      pad_oe_n_reg   <= {`PMX_GPIO_W{1'b1}};
      pad_pullup_reg <= `PMX_ZERO16;
      gpio_in_reg    <= `PMX_ZERO16;
      host_twi_clk_in_reg    <= 1'b1;
      host_twi_data_in_reg   <= 1'b1;
      sensor_twi_clk_in_reg  <= 1'b1;
      sensor_twi_data_in_reg <= 1'b1;
      debug_wire_in_reg      <= 1'b1;
    end else if (clk_en) begin
      pad_out_reg    <= out_next;
      pad_oe_n_reg   <= oe_n_next;
      pad_pullup_reg <= pu_next;
      gpio_in_reg    <= pad_s2_reg;
      host_twi_clk_in_reg    <= pad_s2_reg[`PMX_BIT_HSCL];
      host_twi_data_in_reg   <= pad_s2_reg[`PMX_BIT_HSDA];
      sensor_twi_clk_in_reg  <= sens_bus ? pad_s2_reg[`PMX_BIT_SCLK] : 1'b1;
      sensor_twi_data_in_reg <= sens_bus ? pad_s2_reg[`PMX_BIT_SDAT] : 1'b1;
      debug_wire_in_reg      <= pad_s2_reg[`PMX_BIT_DBG];
    end
  end

  // R15 R16 host interrupt, set wins over clear
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      host_irq_reg <= 1'b0;
    end else if (clk_en) begin
      if (host_irq_set) begin
        host_irq_reg <= 1'b1;
      end else if (resp_tx_start) begin
        host_irq_reg <= 1'b0;
      end
    end
  end

  // R13 wake trigger on its input pad
  assign wake_pin = pad_s2_reg[`PMX_BIT_WAKE];
  always @* begin
    case (wake_trig_mode)
      `PMX_TRIG_RISE: wake_hit = wake_pin && !wake_prev_reg;
      `PMX_TRIG_FALL: wake_hit = !wake_pin && wake_prev_reg;
      `PMX_TRIG_HIGH: wake_hit = wake_pin;
      `PMX_TRIG_LOW:  wake_hit = !wake_pin;
      default:        wake_hit = 1'b0;
    endcase
  end
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // idle pad is pulled high, so no false rise after reset
      wake_prev_reg <= 1'b1;
      wake_req_reg  <= 1'b0;
    end else if (clk_en) begin
      wake_prev_reg <= wake_pin;
      wake_req_reg  <= wake_hit;
    end
  end
  // R14 fixed top priority
  assign wake_level = `PMX_WAKE_LEVEL;
endmodule
`default_nettype wire

/* tb/pmx_pin_mux_sva.sv */
// assertions on the pin mux ports
`timescale 1ns/10ps
`default_nettype none
`include "pmx_defs.vh"
module pmx_pin_mux_sva (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       por_reset,
  input wire logic       clk_en,
  input wire logic       drive_reset_out,
  input wire logic       internal_reset_req,
  input wire logic       ext_reset_pin_n_out,
  input wire logic       ext_reset_pin_n_oe_n,
  input wire logic       host_irq_set,
  input wire logic       resp_tx_start,
  input wire logic       host_irq_reg,
  input wire logic [2:0] wake_level,
  input wire logic       boot_mode_select_reg,
  input wire logic       slave_port_strap_reg
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_no_drive;
    !$past(drive_reset_out) && !$past(drive_reset_out, 2) |-> ext_reset_pin_n_oe_n;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("reset pin driven");
  property p_pull;
    $past(drive_reset_out, 2) && $past(drive_reset_out) && $past(internal_reset_req)
      && !$past(por_reset) |-> !ext_reset_pin_n_oe_n;
  endproperty
  a_pull: assert property (p_pull) else $error("reset pin not pulled");
  property p_por;
    $past(por_reset) |-> ext_reset_pin_n_oe_n;
  endproperty
  a_por: assert property (p_por) else $error("reset pin pulled on power-on");
  property p_low;
    !ext_reset_pin_n_oe_n |-> !ext_reset_pin_n_out;
  endproperty
  a_low: assert property (p_low) else $error("reset pin driven high");
  property p_irq_set;
    clk_en && host_irq_set |=> host_irq_reg;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("host irq not raised");
  property p_irq_clr;
    clk_en && resp_tx_start && !host_irq_set |=> !host_irq_reg;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("host irq not cleared");
  property p_level;
    wake_level == `PMX_WAKE_LEVEL;
  endproperty
  a_level: assert property (p_level) else $error("wake level wrong");
  property p_strap;
    !$past(reset) && !$past(reset, 2) && !$past(reset, 3)
      |-> $stable({boot_mode_select_reg, slave_port_strap_reg});
  endproperty
  a_strap: assert property (p_strap) else $error("strap changed after start");
endmodule

bind pmx_pin_mux pmx_pin_mux_sva u_sva (.*);
`default_nettype wire

/* tb/pmx_far_side.sv */
// board side of the pads: pull-ups, strap and external pull-downs
`timescale 1ns/10ps
`default_nettype none
module pmx_far_side (
  input  wire logic [15:0] pad_out_reg,
  input  wire logic [15:0] pad_oe_n_reg,
  input  wire logic [15:0] ext_low,
  input  wire logic        ext_reset_pin_n_oe_n,
  input  wire logic        rst_ext_low,
  output logic      [15:0] pad_in,
  output logic             ext_reset_pin_n_in
);
  // released pads pulled up unless held low outside
  assign pad_in = (~pad_oe_n_reg & pad_out_reg) | (pad_oe_n_reg & ~ext_low);
  assign ext_reset_pin_n_in = ext_reset_pin_n_oe_n & ~rst_ext_low;
endmodule
`default_nettype wire

/* tb/pmx_pin_mux_tb.sv */
// self-checking bench of the pin mux block
`timescale 1ns/10ps
`default_nettype none
`include "pmx_defs.vh"
module pmx_pin_mux_tb;
  logic        core_clk, reset, por_reset, clk_en, drive_reset_out, internal_reset_req, cfg_wr;
  logic        boot_active, gpio_op_valid, host_twi_clk_out, host_twi_data_out, debug_wire_out;
  logic        host_spi_miso_out, sensor_twi_clk_out, sensor_twi_data_out, delay_out_first;
  logic        delay_out_second, host_irq_set, resp_tx_start, sample_rate, rst_ext_low;
  logic        ext_reset_pin_n_in, ext_reset_pin_n_out, ext_reset_pin_n_oe_n, ext_reset_seen_reg;
  logic        host_twi_clk_in_reg, host_twi_data_in_reg, sensor_twi_clk_in_reg, wake_req_reg;
  logic        sensor_twi_data_in_reg, debug_wire_in_reg, host_irq_reg, analog_enable;
  logic        sample_rate_sync_reg, boot_mode_select_reg, slave_port_strap_reg;
  logic [1:0]  cfg_clk_sel, cfg_data_sel, cfg_host_pullup, gpio_op_code, wake_trig_mode;
  logic [2:0]  wake_level;
  logic [19:0] cfg_mux;
  logic [15:0] cfg_enable, gpio_op_mask, gpio_op_data, gpio_dir_out, gpio_in_reg, pad_in;
  logic [15:0] pad_out_reg, pad_oe_n_reg, pad_pullup_reg, ext_low, q;
  int          num_errors, checked;

  pmx_pin_mux dut (.*);
  pmx_far_side far (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task give_verdict;
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_hi(input string nm, ref logic s);
    for (int n = 0; n < 12 && s !== 1'b1; n++)
      tick(1);
    chk(nm, s, 1'b1);
    if (s !== 1'b1)
      give_verdict;
  endtask

  // pads are looked at one edge after the write is taken
  task cfg(input logic [15:0] en, input logic [1:0] sel, input logic [19:0] mux);
    @(posedge core_clk);
    {cfg_wr, cfg_enable, cfg_clk_sel, cfg_data_sel, cfg_mux} <= {1'b1, en, sel, sel, mux};
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    tick(1);
  endtask

  task gop(input logic [1:0] op, input logic [15:0] m);
    @(posedge core_clk);
    {gpio_op_valid, gpio_op_code, gpio_op_mask, gpio_op_data} <= {1'b1, op, m, m};
    @(posedge core_clk);
    gpio_op_valid <= 1'b0;
    tick(1);
  endtask

  task t_reset_state;
    chk("state", {ext_reset_pin_n_oe_n, analog_enable, host_twi_data_in_reg,
        boot_mode_select_reg, slave_port_strap_reg}, 5'h16);
    chk("pads", {pad_oe_n_reg, pad_pullup_reg, pad_out_reg & 16'hc001},
        {16'h3ffe, 16'h0000, 16'h0000});
    @(posedge core_clk);
    {host_twi_clk_out, sensor_twi_clk_out, sensor_twi_data_out, por_reset} <= 4'he;
    ext_low <= 16'h0000;
  endtask

  task t_rst_pin;
    @(posedge core_clk);
    internal_reset_req <= 1'b1;
    tick(3);
    chk("no drive", ext_reset_pin_n_oe_n, 1'b1);
    @(posedge core_clk);
    drive_reset_out <= 1'b1;
    tick(3);
    chk("drive", {ext_reset_pin_n_oe_n, ext_reset_pin_n_out, ext_reset_seen_reg}, 3'h0);
    @(posedge core_clk);
    {por_reset, internal_reset_req, rst_ext_low} <= 3'h7;
    tick(5);
    chk("seen", {ext_reset_pin_n_oe_n, ext_reset_seen_reg}, 2'h3);
    @(posedge core_clk);
    {por_reset, internal_reset_req, rst_ext_low} <= 3'h0;
  endtask

  task t_gpio;
    logic [15:0] v [4];
    v = '{16'hffff, 16'h0f00, 16'h00f0, 16'h3c3c};
    cfg(16'hffff, `PMX_SEL_SENS_DEF, `PMX_MUX_RESET);
    chk("oe", pad_oe_n_reg, 16'hc203);
    for (int i = 0; i < 4; i++) begin
      gop(i[1:0], v[i]);
      q = (i == 0) ? v[0] : (i == 1) ? q | v[1] : (i == 2) ? q & ~v[2] : q ^ v[3];
      chk("out", pad_out_reg & 16'h3dfc, q & 16'h3dfc);
    end
    cfg(16'hffff, `PMX_SEL_GPIO, 20'h0_0042);
    chk("all", {pad_oe_n_reg, pad_out_reg} & 32'hfff3_fff3, {16'h0000, q & 16'hfff3});
    cfg(16'hffff, `PMX_SEL_SENS_ALT, `PMX_MUX_RESET);
    chk("alt", pad_oe_n_reg, 16'hc203);
  endtask

  task t_irq;
    cfg(16'h0000, `PMX_SEL_SENS_DEF, 20'h0_0008);
    @(posedge core_clk);
    host_irq_set <= 1'b1;
    tick(1);
    chk("irq set", host_irq_reg, 1'b1);
    @(posedge core_clk);
    {host_irq_set, resp_tx_start} <= 2'h3;
    tick(1);
    chk("irq both", {host_irq_reg, pad_oe_n_reg[5], pad_out_reg[5]}, 3'h5);
    @(posedge core_clk);
    host_irq_set <= 1'b0;
    tick(1);
    chk("irq clr", host_irq_reg, 1'b0);
    @(posedge core_clk);
    {clk_en, host_irq_set, resp_tx_start} <= 3'h2;
    tick(2);
    chk("frozen", host_irq_reg, 1'b0);
    @(posedge core_clk);
    {clk_en, host_irq_set} <= 2'h2;
  endtask

  task t_wake;
    logic [3:0] act;
    act = 4'h5;
    cfg(16'h0000, `PMX_SEL_SENS_DEF, `PMX_MUX_RESET);
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      {wake_trig_mode, ext_low[4]} <= {m[1:0], act[m]};
      tick(6);
      chk("wake idle", wake_req_reg, 1'b0);
      @(posedge core_clk);
      ext_low[4] <= ~act[m];
      wait_hi("wake", wake_req_reg);
    end
  endtask

  task t_misc;
    @(posedge core_clk);
    {sample_rate, host_spi_miso_out, delay_out_first, delay_out_second} <= 4'hf;
    wait_hi("rate", sample_rate_sync_reg);
    cfg(16'h0000, `PMX_SEL_SENS_DEF, 20'h0_0035);
    chk("mux", {analog_enable, pad_oe_n_reg & 16'h0124, pad_out_reg & 16'h0120},
        {1'b1, 16'h0004, 16'h0120});
    @(posedge core_clk);
    boot_active <= 1'b1;
    cfg(16'h0000, `PMX_SEL_SENS_DEF, 20'h0_0035);
    chk("spi", {pad_oe_n_reg[2], pad_out_reg[2]}, 2'h1);
  endtask

  task t_inputs;
    @(posedge core_clk);
    {cfg_host_pullup, gpio_dir_out, ext_low} <= {2'h2, 16'h0000, 16'ha5c3};
    cfg(16'hffff, `PMX_SEL_SENS_DEF, `PMX_MUX_RESET);
    tick(3);
    chk("in", {pad_oe_n_reg, gpio_in_reg}, {16'hffff, 16'h5a3c});
    chk("twi in", {host_twi_clk_in_reg, host_twi_data_in_reg, sensor_twi_clk_in_reg,
        sensor_twi_data_in_reg, debug_wire_in_reg}, 5'h05);
    chk("pullup", pad_pullup_reg, 16'h0002);
  endtask

  initial begin
    {reset, por_reset, clk_en, debug_wire_out, host_twi_data_out} = 5'h1f;
    {drive_reset_out, internal_reset_req, cfg_wr, boot_active, gpio_op_valid} = '0;
    {host_twi_clk_out, host_spi_miso_out, sensor_twi_clk_out, sensor_twi_data_out} = '0;
    {delay_out_first, delay_out_second, host_irq_set, resp_tx_start, sample_rate} = '0;
    {cfg_enable, cfg_clk_sel, cfg_data_sel, cfg_mux, cfg_host_pullup} = '0;
    {gpio_op_code, gpio_op_mask, gpio_op_data, wake_trig_mode, rst_ext_low, q} = '0;
    gpio_dir_out = 16'hffff;
    // slave port strap held low across start-up
    ext_low = 16'h0100;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    tick(5);
    t_reset_state;
    t_rst_pin;
    t_gpio;
    t_irq;
    t_wake;
    t_misc;
    t_inputs;
    give_verdict;
  end
endmodule
`default_nettype wire
